// ===== design/acs_sequencer.v
// Behaviour
// - Eight-bit result by successive approximation search.
// - Four channels, two-bit field selects one.
// - Reference is supply or shared reference pin.
// - Conversion runs on in sleep with RC.
// - Port pins come out of reset analog.
// - Port read gives zero on analog pins.
// - Completion loads result and clears busy bit.
// - Completion sets the done flag bit six.
// - Two bit periods between conversion and acquisition.
// - Conversion and recovery counted in half conversion-bit periods; RC start delay in clocks.
// - Clock select: divide 2, 8, 32, RC.
// - One conversion takes nine and half periods.
// - Clearing busy aborts, result keeps old value.
// - Enable cleared powers converter fully down.
`include "acs_defs.vh"
`default_nettype none

module acs_sequencer (
   input wire CLK,
   input wire RESET,
   input wire CE,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WE,
   input wire RE,
   output reg [7:0] RDATA,
   input wire [3:0] PORT_PINS,
   input wire SLEEP,
   input wire RC_TICK,
   input wire COMP_HIGH,
   output wire [7:0] TRIAL_CODE,
   output wire [1:0] CHANNEL_SEL,
   output wire REF_SEL,
   output wire SAMPLE_CONNECT,
   output wire ANALOG_POWER,
   output wire CONVERTING,
   output wire WAKE
);

   // ---------------------------------------------------------------
   // States and helpers
   // ---------------------------------------------------------------
   localparam [1:0] ST_ACQ = 2'd0;
   localparam [1:0] ST_DELAY = 2'd1;
   localparam [1:0] ST_CONV = 2'd2;
   localparam [1:0] ST_RECOV = 2'd3;

   // Clocks per half bit period for the divided sources.
   function [4:0] half_len;
      input [1:0] sel;
      begin
         case (sel)
            `ACS_CLKSEL_DIV2: half_len = 5'h01;
            `ACS_CLKSEL_DIV8: half_len = 5'h04;
            default: half_len = 5'h10;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0] ctrl_reg;
   reg [7:0] cfg_reg;
   reg [7:0] result_reg;
   reg flag_reg;
   reg irq_en_reg;
   reg [1:0] state_reg;
   reg [4:0] div_reg;
   reg [4:0] half_reg;
   reg [2:0] delay_reg;
   reg [7:0] sar_reg;

   wire enable = ctrl_reg[`ACS_CTRL_ENABLE_BIT];
   wire go = ctrl_reg[`ACS_CTRL_GO_BIT];
   wire [1:0] clk_sel = ctrl_reg[`ACS_CTRL_CLKSEL_LO+1:`ACS_CTRL_CLKSEL_LO];
   wire rc_mode = (clk_sel == `ACS_CLKSEL_RC);
   // Sleep stops the divided clock, so only the RC source keeps going.
   wire sleep_kill = SLEEP && !rc_mode;
   wire running = (state_reg == ST_CONV) || (state_reg == ST_RECOV);

   // ---------------------------------------------------------------
   // Bit period timebase
   // ---------------------------------------------------------------
   // Source selection
   wire div_wrap = (div_reg == half_len(clk_sel) - 5'h01);
   wire half_tick = rc_mode ? RC_TICK : div_wrap;

   // The trial bit moves down one place after each decision, MSB first.
   wire [4:0] half_less = half_reg - 5'h01;
   wire [2:0] bit_idx = (half_reg == 5'h00) ? 3'h0 : half_less[3:1];
   wire decide = (state_reg == ST_CONV) && half_tick && !half_reg[0] && (half_reg != 5'h00) &&
      (half_reg < 5'h12);
   wire conv_end = (state_reg == ST_CONV) && half_tick && (half_reg == `ACS_CONV_HALVES - 5'h01);
   wire recov_end = (state_reg == ST_RECOV) && half_tick && (half_reg == `ACS_RECOV_HALVES - 5'h01);
   wire abort = (state_reg == ST_CONV || state_reg == ST_DELAY) && (!go || !enable || sleep_kill);

   assign TRIAL_CODE = CONVERTING ? (sar_reg | (8'h80 >> bit_idx)) : 8'h00;
   assign CHANNEL_SEL = ctrl_reg[`ACS_CTRL_CHAN_LO+1:`ACS_CTRL_CHAN_LO];
   assign REF_SEL = cfg_reg[`ACS_CFG_REFSEL_BIT];
   // Holding capacitor off while converting and recovering
   assign SAMPLE_CONNECT = ANALOG_POWER && (state_reg == ST_ACQ || state_reg == ST_DELAY);
   assign ANALOG_POWER = enable && !sleep_kill;
   // An unpowered conversion is dead already in the cycle before the abort edge.
   assign CONVERTING = (state_reg == ST_CONV) && ANALOG_POWER;
   // Done event may wake the core
   assign WAKE = flag_reg && irq_en_reg;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always @(posedge CLK) begin
      if (RESET) begin
         state_reg <= ST_ACQ;
         div_reg <= 5'h00;
         half_reg <= 5'h00;
         delay_reg <= 3'h0;
         sar_reg <= 8'h00;
      end else if (CE) begin
         if (!running || div_wrap || rc_mode) begin
            div_reg <= 5'h00;
         end else begin
            div_reg <= div_reg + 5'h01;
         end
         if (half_tick) begin
            half_reg <= half_reg + 5'h01;
         end
         case (state_reg)
            ST_ACQ: begin
               half_reg <= 5'h00;
               sar_reg <= 8'h00;
               if (go && enable) begin
                  // RC start waits one instruction cycle
                  if (rc_mode) begin
                     delay_reg <= `ACS_SLEEP_START_CLKS;
                     state_reg <= ST_DELAY;
                  end else begin
                     state_reg <= ST_CONV;
                  end
               end
            end
            ST_DELAY: begin
               half_reg <= 5'h00;
               delay_reg <= delay_reg - 3'h1;
               if (abort) begin
                  state_reg <= ST_ACQ;
               end else if (delay_reg == 3'h1) begin
                  state_reg <= ST_CONV;
               end
            end
            ST_CONV: begin
               // Keep bit when input is above trial
               if (decide && COMP_HIGH) begin
                  sar_reg <= sar_reg | (8'h80 >> bit_idx);
               end
               if (abort || conv_end) begin
                  half_reg <= 5'h00;
                  div_reg <= 5'h00;
                  state_reg <= ST_RECOV;
               end
            end
            ST_RECOV: begin
               // Two bit periods before next acquisition
               if (recov_end || sleep_kill || !enable) begin
                  half_reg <= 5'h00;
                  state_reg <= ST_ACQ;
               end
            end
            default: state_reg <= ST_ACQ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   wire wr_ctrl = WE && (ADDR == `ACS_ADDR_CTRL_MAIN);
   wire wr_flags = WE && (ADDR == `ACS_ADDR_FLAGS);
   wire done_evt = conv_end && !abort;

   always @(posedge CLK) begin
      if (RESET) begin
         ctrl_reg <= `ACS_CTRL_MAIN_RESET;
         cfg_reg <= `ACS_PORT_CFG_RESET;
         result_reg <= `ACS_RESULT_RESET;
         flag_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         RDATA <= 8'h00;
      end else if (CE) begin
         if (wr_ctrl) begin
            ctrl_reg <= {WDATA[7:6], 1'b0, WDATA[4:3], 1'b0, 1'b0, WDATA[0]};
            // Start needs the converter already on
            ctrl_reg[`ACS_CTRL_GO_BIT] <= WDATA[`ACS_CTRL_GO_BIT] && WDATA[0] && enable;
         end
         // Completion clears busy and loads result
         if (done_evt) begin
            ctrl_reg[`ACS_CTRL_GO_BIT] <= 1'b0;
            result_reg <= sar_reg;
         end else if (WE && ADDR == `ACS_ADDR_RESULT) begin
            result_reg <= WDATA;
         end
         // A non-RC sleep cancels the conversion but keeps enable set.
         if (sleep_kill && go) begin
            ctrl_reg[`ACS_CTRL_GO_BIT] <= 1'b0;
         end
         if (WE && ADDR == `ACS_ADDR_PORT_CFG) begin
            cfg_reg <= {3'b000, WDATA[4:0]};
         end
         if (WE && ADDR == `ACS_ADDR_IRQ_EN) begin
            irq_en_reg <= WDATA[`ACS_IRQ_EN_BIT];
         end
         // Set wins over a software clear in the same cycle
         if (done_evt) begin
            flag_reg <= 1'b1;
         end else if (wr_flags) begin
            flag_reg <= WDATA[`ACS_FLAG_DONE_BIT];
         end
         if (RE) begin
            case (ADDR)
               `ACS_ADDR_PORT: RDATA <= {4'h0, PORT_PINS & cfg_reg[3:0]};
               `ACS_ADDR_FLAGS: RDATA <= {1'b0, flag_reg, 6'h00};
               `ACS_ADDR_RESULT: RDATA <= result_reg;
               `ACS_ADDR_CTRL_MAIN: RDATA <= ctrl_reg;
               `ACS_ADDR_IRQ_EN: RDATA <= {1'b0, irq_en_reg, 6'h00};
               `ACS_ADDR_PORT_CFG: RDATA <= cfg_reg;
               default: RDATA <= 8'h00;
            endcase
         end
      end
   end

endmodule // acs_sequencer

`default_nettype wire

// ===== common/acs_defs.vh
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define ACS_ADDR_PORT 8'h05
`define ACS_ADDR_FLAGS 8'h0C
`define ACS_ADDR_RESULT 8'h1E
`define ACS_ADDR_CTRL_MAIN 8'h1F
`define ACS_ADDR_IRQ_EN 8'h8C
`define ACS_ADDR_PORT_CFG 8'h9F

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACS_CTRL_ENABLE_BIT 0
`define ACS_CTRL_GO_BIT 2
`define ACS_CTRL_CHAN_LO 3
`define ACS_CTRL_CLKSEL_LO 6
`define ACS_FLAG_DONE_BIT 6
`define ACS_IRQ_EN_BIT 6
`define ACS_CFG_REFSEL_BIT 4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ACS_CTRL_MAIN_RESET 8'h00
`define ACS_PORT_CFG_RESET 8'h00
`define ACS_RESULT_RESET 8'h00

// ---------------------------------------------------------------
// Clock select codes and timing counts; conversion and recovery in half conversion-bit periods, RC start delay in clocks
// ---------------------------------------------------------------
`define ACS_CLKSEL_DIV2 2'h0
`define ACS_CLKSEL_DIV8 2'h1
`define ACS_CLKSEL_DIV32 2'h2
`define ACS_CLKSEL_RC 2'h3
`define ACS_CONV_HALVES 5'h13
`define ACS_RECOV_HALVES 5'h04
`define ACS_SLEEP_START_CLKS 3'h4

`endif

// ===== dv/acs_seq_sva.sv
`include "acs_defs.vh"
`default_nettype none
// ---
// Sequencer port checks.
// ---
module acs_seq_sva (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic [7:0] ADDR,
   input wire logic WE,
   input wire logic RE,
   input wire logic [7:0] RDATA,
   input wire logic [7:0] TRIAL_CODE,
   input wire logic SAMPLE_CONNECT,
   input wire logic ANALOG_POWER,
   input wire logic CONVERTING,
   input wire logic WAKE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   trial_idle_a: assert property (!CONVERTING |-> TRIAL_CODE == 8'h00) else $error("trial not idle");
   msb_first_a: assert property ($rose(CONVERTING) |-> TRIAL_CODE == 8'h80) else $error("no msb trial");
   hold_open_a: assert property (CONVERTING |-> !SAMPLE_CONNECT) else $error("sampling in conversion");
   recovery_gap_a: assert property ($fell(CONVERTING) |-> !SAMPLE_CONNECT [*4]) else $error("short gap");
   conv_power_a: assert property (CONVERTING |-> ANALOG_POWER) else $error("converting unpowered");
   flag_sticky_a: assert property ($fell(WAKE) |-> $past(CE && WE && (ADDR == `ACS_ADDR_FLAGS || ADDR == `ACS_ADDR_IRQ_EN)))
      else $error("flag self cleared");
   rdata_hold_a: assert property (!$past(RE && CE) |-> $stable(RDATA)) else $error("read data moved");
   port_zero_a: assert property (CE && RE && ADDR == `ACS_ADDR_PORT |=> RDATA[7:4] == 4'h0)
      else $error("port high bits set");
   ctrl_rsv_a: assert property (CE && RE && ADDR == `ACS_ADDR_CTRL_MAIN |=> !RDATA[5] && !RDATA[1])
      else $error("reserved bit set");
endmodule // acs_seq_sva
bind acs_sequencer acs_seq_sva u_sva (.CLK(CLK), .RESET(RESET), .CE(CE), .ADDR(ADDR), .WE(WE), .RE(RE),
   .RDATA(RDATA), .TRIAL_CODE(TRIAL_CODE), .SAMPLE_CONNECT(SAMPLE_CONNECT), .ANALOG_POWER(ANALOG_POWER),
   .CONVERTING(CONVERTING), .WAKE(WAKE));
`default_nettype wire

// ===== dv/acs_analog_model.sv
`default_nettype none
// ---
// Analog inputs and comparator.
// ---
module acs_analog_model #(
   parameter logic [7:0] L0 = 8'h00,
   parameter logic [7:0] L1 = 8'h00,
   parameter logic [7:0] L2 = 8'h00,
   parameter logic [7:0] L3 = 8'h00
) (
   input wire logic [1:0] CHANNEL_SEL,
   input wire logic [7:0] TRIAL_CODE,
   output logic COMP_HIGH
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] held;
   assign held = CHANNEL_SEL[1] ? (CHANNEL_SEL[0] ? L3 : L2) : (CHANNEL_SEL[0] ? L1 : L0);
   assign COMP_HIGH = held >= TRIAL_CODE;
endmodule // acs_analog_model
`default_nettype wire

// ===== dv/tb.sv
`include "acs_defs.vh"
`default_nettype none
// ---
// Sequencer bench.
// ---
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] LVL [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h00};
   logic CLK = 0, RESET = 1, CE = 1, WE = 0, RE = 0, SLEEP = 0, RC_TICK = 0;
   logic [7:0] ADDR = 0, WDATA = 0, RDATA, TRIAL_CODE, v;
   logic [3:0] PORT_PINS = 4'hA;
   logic [2:0] rc = 0;
   logic [1:0] CHANNEL_SEL;
   logic REF_SEL, SAMPLE_CONNECT, ANALOG_POWER, CONVERTING, WAKE, COMP_HIGH;
   int miscompares = 0, checks = 0;
   always #20 CLK = ~CLK;
   always @(posedge CLK) begin
      rc <= rc + 3'h1;
      RC_TICK <= rc == 3'h4;
   end
   acs_sequencer dut (.CLK(CLK), .RESET(RESET), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WE(WE), .RE(RE),
      .RDATA(RDATA), .PORT_PINS(PORT_PINS), .SLEEP(SLEEP), .RC_TICK(RC_TICK), .COMP_HIGH(COMP_HIGH),
      .TRIAL_CODE(TRIAL_CODE), .CHANNEL_SEL(CHANNEL_SEL), .REF_SEL(REF_SEL), .SAMPLE_CONNECT(SAMPLE_CONNECT),
      .ANALOG_POWER(ANALOG_POWER), .CONVERTING(CONVERTING), .WAKE(WAKE));
   acs_analog_model #(.L0(LVL[0]), .L1(LVL[1]), .L2(LVL[2]), .L3(LVL[3])) u_model (
      .CHANNEL_SEL(CHANNEL_SEL), .TRIAL_CODE(TRIAL_CODE), .COMP_HIGH(COMP_HIGH));
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WE <= 1;
      @(posedge CLK);
      WE <= 0;
      // Returning on the falling edge lets callers look at settled outputs.
      @(negedge CLK);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      RE <= 1;
      @(posedge CLK);
      RE <= 0;
      @(negedge CLK);
      d = RDATA;
   endtask
   // Runs one conversion; a zero length skips the duration check.
   task automatic conv(input logic [1:0] cs, input logic [1:0] ch, input int len);
      int n;
      n = 0;
      wr(`ACS_ADDR_FLAGS, 8'h00);
      wr(`ACS_ADDR_CTRL_MAIN, {cs, 1'b0, ch, 3'b001});
      wr(`ACS_ADDR_CTRL_MAIN, {cs, 1'b0, ch, 3'b101});
      for (int i = 0; i < 3000 && (n == 0 || CONVERTING); i++) begin
         @(negedge CLK);
         if (CONVERTING === 1'b1) n++;
      end
      if (n == 0 || CONVERTING !== 1'b0) begin
         miscompares++;
         conclude();
      end
      chk("chan", 16'(ch), 16'(CHANNEL_SEL));
      if (len > 0) chk("length", 16'(len), 16'(n));
      rd(`ACS_ADDR_RESULT, v);
      chk("result", 16'(LVL[ch]), 16'(v));
      rd(`ACS_ADDR_CTRL_MAIN, v);
      chk("ctrl", 16'({cs, 1'b0, ch, 3'b001}), 16'(v));
      rd(`ACS_ADDR_FLAGS, v);
      chk("flag", 16'h0040, 16'(v & 8'h40));
      chk("wake", 16'h0001, 16'(WAKE));
   endtask
   task automatic s_reset();
      foreach (LVL[i]) begin
         rd(8'(i) * 8'h40 + 8'h05, v);
         chk("reset", 16'h0000, 16'(v));
      end
      rd(`ACS_ADDR_CTRL_MAIN, v);
      chk("ctrl", 16'h0000, 16'(v));
      chk("power", 16'h0000, 16'(ANALOG_POWER));
   endtask
   task automatic s_abort();
      wr(`ACS_ADDR_FLAGS, 8'h00);
      wr(`ACS_ADDR_CTRL_MAIN, 8'h89);
      wr(`ACS_ADDR_CTRL_MAIN, 8'h8D);
      repeat (40) @(negedge CLK);
      wr(`ACS_ADDR_CTRL_MAIN, 8'h89);
      repeat (80) @(negedge CLK);
      chk("abort", 16'h0000, 16'(CONVERTING));
      rd(`ACS_ADDR_RESULT, v);
      chk("kept", 16'(LVL[0]), 16'(v));
      // A sleep on a divided clock must kill the conversion but keep enable set.
      wr(`ACS_ADDR_CTRL_MAIN, 8'h8D);
      repeat (40) @(negedge CLK);
      @(posedge CLK);
      SLEEP <= 1;
      repeat (80) @(negedge CLK);
      chk("asleep", 16'h0000, 16'({ANALOG_POWER, CONVERTING}));
      @(posedge CLK);
      SLEEP <= 0;
      rd(`ACS_ADDR_CTRL_MAIN, v);
      chk("killed", 16'h0089, 16'(v));
      rd(`ACS_ADDR_RESULT, v);
      chk("unloaded", 16'(LVL[0]), 16'(v));
      rd(`ACS_ADDR_FLAGS, v);
      chk("noflag", 16'h0000, 16'(v & 8'h40));
   endtask
   task automatic s_off();
      wr(`ACS_ADDR_CTRL_MAIN, 8'h00);
      chk("off", 16'h0000, 16'(ANALOG_POWER));
      wr(`ACS_ADDR_CTRL_MAIN, 8'h04);
      rd(`ACS_ADDR_CTRL_MAIN, v);
      chk("nogo", 16'h0000, 16'({v, 7'h00, CONVERTING}));
      wr(`ACS_ADDR_PORT_CFG, 8'h1F);
      rd(`ACS_ADDR_PORT, v);
      chk("port", 16'h000A, 16'(v));
      chk("ref", 16'h0001, 16'(REF_SEL));
      wr(`ACS_ADDR_PORT_CFG, 8'h03);
      rd(`ACS_ADDR_PORT, v);
      chk("mixed", 16'h0002, 16'({REF_SEL, v}));
      // With the clock enable low a write must not land.
      @(posedge CLK);
      CE <= 0;
      wr(`ACS_ADDR_PORT_CFG, 8'h1F);
      @(posedge CLK);
      CE <= 1;
      rd(`ACS_ADDR_PORT_CFG, v);
      chk("frozen", 16'h0003, 16'({REF_SEL, v}));
   endtask
   initial begin
      repeat (20) @(posedge CLK);
      RESET <= 0;
      s_reset();
      wr(`ACS_ADDR_IRQ_EN, 8'h40);
      for (int c = 0; c < 3; c++) conv(2'(c), 2'(c), 19 << (2 * c));
      conv(2'h3, 2'h3, 0);
      @(posedge CLK);
      SLEEP <= 1;
      // Only the RC source may keep running while asleep.
      conv(2'h3, 2'h0, 0);
      wr(`ACS_ADDR_CTRL_MAIN, 8'h01);
      chk("sleep", 16'h0000, 16'(ANALOG_POWER));
      @(posedge CLK);
      SLEEP <= 0;
      s_abort();
      s_off();
      conclude();
   end
endmodule // tb
`default_nettype wire
